// ### src/fbst_pkg.sv
package fbst_pkg;

   localparam int          FBST_IR_WIDTH     = 4;
   localparam int          FBST_ID_WIDTH     = 32;
   localparam int          FBST_DATA_WIDTH   = 36;
   localparam int          FBST_PTR_WIDTH    = 16;
   localparam int          FBST_TMS_RESET_N  = 5;

   // Instruction codes
   localparam logic [3:0]  FBST_INS_EXTEST   = 4'h0;
   localparam logic [3:0]  FBST_INS_IDCODE   = 4'h2;
   localparam logic [3:0]  FBST_INS_BYPASS   = 4'hF;
   // Value captured into the instruction register, ends in 01
   localparam logic [3:0]  FBST_IR_CAPTURE   = 4'h1;
   // Arbitrary neutral identification value
   localparam logic [31:0] FBST_ID_VALUE     = 32'h0000_0001;

   typedef enum logic [3:0] {
      FBST_TLR, FBST_RTI, FBST_SEL_DR, FBST_CAP_DR, FBST_SHF_DR, FBST_EX1_DR, FBST_PAU_DR, FBST_EX2_DR,
      FBST_UPD_DR, FBST_SEL_IR, FBST_CAP_IR, FBST_SHF_IR, FBST_EX1_IR, FBST_PAU_IR, FBST_EX2_IR, FBST_UPD_IR
   } fbst_state_type;

endpackage

// ### src/fbst_tap.sv
// Behaviour
// - All test logic steps on test clock; sample rising, outputs change falling.
// - Shift serial input on rising edge into selected instruction, ID or bypass.
// - Serial output comes from selected register, updated on falling edge.
// - Serial output high impedance except in Shift-DR or Shift-IR.
// - Mode select steers the standard sixteen-state TAP controller.
// - Test reset forces the controller to reset state without test clock.
// - No power-up reset; test reset or five high mode-select cycles reset it.
// - FIFO data outputs stay high impedance until TAP properly reset.
// - Master reset clears read and write pointers and output register.
`timescale 1ns/1ps
module fbst_tap
   import fbst_pkg::*;
#(
   parameter int DATA_WIDTH = FBST_DATA_WIDTH,
   parameter int PTR_WIDTH  = FBST_PTR_WIDTH
) (
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tdi,
   input  wire logic                  trst_b,
   input  wire logic                  fifo_master_reset_b,
   input  wire logic [DATA_WIDTH-1:0] fifo_read_data,
   output logic                       tdo_o,
   output logic                       tdo_oe,
   output logic [DATA_WIDTH-1:0]      fifo_data_outputs,
   output logic                       fifo_data_outputs_oe,
   output logic [PTR_WIDTH-1:0]       read_ptr_reg,
   output logic [PTR_WIDTH-1:0]       write_ptr_reg
);

   // Two-stage synchronisers for pins from outside the mclk domain
   logic [2:0]                  tck_sync_reg;
   logic [1:0]                  tms_sync_reg;
   logic [1:0]                  tdi_sync_reg;
   logic [1:0]                  trst_sync_reg;
   logic [1:0]                  mrs_sync_reg;
   fbst_state_type              state_reg;
   fbst_state_type              state_next;
   logic [FBST_IR_WIDTH-1:0]    ir_shift_reg;
   logic [FBST_IR_WIDTH-1:0]    ir_reg;
   logic [FBST_ID_WIDTH-1:0]    id_shift_reg;
   logic                        bypass_reg;
   logic                        tap_was_reset_reg;
   logic                        tms_s;
   logic                        tdi_s;
   logic                        tck_rise;
   logic                        tck_fall;
   logic                        trst_active;
   logic                        mrs_active;
   logic                        sel_id;
   logic                        in_shift_ir;
   logic                        in_shift_dr;
   logic                        dr_bit;
   logic                        serial_bit;

   assign tms_s       = tms_sync_reg[1];
   assign tdi_s       = tdi_sync_reg[1];
   // Third stage only delays the synchronised level for edge finding
   assign tck_rise    = tck_sync_reg[1] & ~tck_sync_reg[2];
   assign tck_fall    = ~tck_sync_reg[1] & tck_sync_reg[2];
   assign trst_active = ~trst_sync_reg[1];
   assign mrs_active  = ~mrs_sync_reg[1];
   // Every code other than the ID code selects the bypass stage
   assign sel_id      = (ir_reg == FBST_INS_IDCODE);
   assign in_shift_ir = (state_reg == FBST_SHF_IR);
   assign in_shift_dr = (state_reg == FBST_SHF_DR);
   assign dr_bit      = sel_id ? id_shift_reg[0] : bypass_reg;
   assign serial_bit  = in_shift_ir ? ir_shift_reg[0] : dr_bit;

   // Idle low like the pin, so no false rise follows reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tck_sync_reg <= 3'h0;
      end else begin
         tck_sync_reg <= {tck_sync_reg[1:0], tck};
      end
   end

   // Pull-up level for the mode and data pins
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tms_sync_reg <= 2'h3;
      end else begin
         tms_sync_reg <= {tms_sync_reg[0], tms};
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tdi_sync_reg <= 2'h3;
      end else begin
         tdi_sync_reg <= {tdi_sync_reg[0], tdi};
      end
   end

   // Inactive after reset: rst_b alone must leave the TAP unreset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         trst_sync_reg <= 2'h3;
      end else begin
         trst_sync_reg <= {trst_sync_reg[0], trst_b};
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mrs_sync_reg <= 2'h0;
      end else begin
         mrs_sync_reg <= {mrs_sync_reg[0], fifo_master_reset_b};
      end
   end

   // Standard transitions; five high samples from anywhere reach reset state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         FBST_TLR:    state_next = tms_s ? FBST_TLR    : FBST_RTI;
         FBST_RTI:    state_next = tms_s ? FBST_SEL_DR : FBST_RTI;
         FBST_SEL_DR: state_next = tms_s ? FBST_SEL_IR : FBST_CAP_DR;
         FBST_CAP_DR: state_next = tms_s ? FBST_EX1_DR : FBST_SHF_DR;
         FBST_SHF_DR: state_next = tms_s ? FBST_EX1_DR : FBST_SHF_DR;
         FBST_EX1_DR: state_next = tms_s ? FBST_UPD_DR : FBST_PAU_DR;
         FBST_PAU_DR: state_next = tms_s ? FBST_EX2_DR : FBST_PAU_DR;
         FBST_EX2_DR: state_next = tms_s ? FBST_UPD_DR : FBST_SHF_DR;
         FBST_UPD_DR: state_next = tms_s ? FBST_SEL_DR : FBST_RTI;
         FBST_SEL_IR: state_next = tms_s ? FBST_TLR    : FBST_CAP_IR;
         FBST_CAP_IR: state_next = tms_s ? FBST_EX1_IR : FBST_SHF_IR;
         FBST_SHF_IR: state_next = tms_s ? FBST_EX1_IR : FBST_SHF_IR;
         FBST_EX1_IR: state_next = tms_s ? FBST_UPD_IR : FBST_PAU_IR;
         FBST_PAU_IR: state_next = tms_s ? FBST_EX2_IR : FBST_PAU_IR;
         FBST_EX2_IR: state_next = tms_s ? FBST_UPD_IR : FBST_SHF_IR;
         FBST_UPD_IR: state_next = tms_s ? FBST_SEL_DR : FBST_RTI;
         default:     state_next = FBST_TLR;
      endcase
   end

   // rst_b alone loads Select-DR, not the reset state: only trst or tms can reset the TAP
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= FBST_SEL_DR;
      end else if (trst_active) begin
         state_reg <= FBST_TLR;
      end else if (tck_rise) begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tap_was_reset_reg <= 1'b0;
      end else if (state_reg == FBST_TLR) begin
         tap_was_reset_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ir_shift_reg <= FBST_IR_CAPTURE;
         id_shift_reg <= FBST_ID_VALUE;
         bypass_reg   <= 1'b0;
      end else if (tck_rise) begin
         case (state_reg)
            FBST_CAP_IR: ir_shift_reg <= FBST_IR_CAPTURE;
            FBST_SHF_IR: ir_shift_reg <= {tdi_s, ir_shift_reg[FBST_IR_WIDTH-1:1]};
            FBST_CAP_DR: begin
               id_shift_reg <= FBST_ID_VALUE;
               bypass_reg   <= 1'b0;
            end
            FBST_SHF_DR: begin
               if (sel_id) begin
                  id_shift_reg <= {tdi_s, id_shift_reg[FBST_ID_WIDTH-1:1]};
               end else begin
                  bypass_reg <= tdi_s;
               end
            end
            default: ;
         endcase
      end
   end

   // Instruction register updates on the falling edge in Update-IR
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ir_reg <= FBST_INS_IDCODE;
      end else if (state_reg == FBST_TLR) begin
         ir_reg <= FBST_INS_IDCODE;
      end else if (tck_fall && state_reg == FBST_UPD_IR) begin
         ir_reg <= ir_shift_reg;
      end
   end

   // Output stage changes on falling test clock; test reset drops the enable at once
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tdo_o  <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (trst_active) begin
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo_o  <= serial_bit;
         tdo_oe <= in_shift_ir | in_shift_dr;
      end
   end

   // Pointers and output register, cleared by master reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         read_ptr_reg      <= '0;
         write_ptr_reg     <= '0;
         fifo_data_outputs <= '0;
      end else if (mrs_active) begin
         read_ptr_reg      <= '0;
         write_ptr_reg     <= '0;
         fifo_data_outputs <= '0;
      end else begin
         fifo_data_outputs <= fifo_read_data;
      end
   end

   // Data pins driven only once the TAP has seen its reset state
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fifo_data_outputs_oe <= 1'b0;
      end else begin
         fifo_data_outputs_oe <= tap_was_reset_reg & ~trst_active;
      end
   end

endmodule // fbst_tap

// ### testbench/fbst_ctrl_model.sv
`timescale 1ns/1ps
module fbst_ctrl_model (
   output logic     tck,
   output logic     tms,
   output logic     tdi,
   output logic     trst_b,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_b = 1'b1;
   end
   // Read tdo just ahead of the rise, long after the fall settled
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #62.5 q = tdo;
      tck = 1'b1;
      #62.5 tck = 1'b0;
   endtask
   task automatic walk(input logic [7:0] p, input int n);
      logic q;
      for (int i = 0; i < n; i++) step(p[i], 1'b1, q);
   endtask
   task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
   endtask
   task automatic set_trst(input logic v);
      trst_b = v;
   endtask
endmodule // fbst_ctrl_model

// ### testbench/fbst_tap_assertions.sv
`timescale 1ns/1ps
module fbst_tap_assertions #(
   parameter int DATA_WIDTH = 36,
   parameter int PTR_WIDTH  = 16
) (
   input wire logic                  mclk,
   input wire logic                  rst_b,
   input wire logic                  tck,
   input wire logic                  trst_b,
   input wire logic                  fifo_master_reset_b,
   input wire logic [DATA_WIDTH-1:0] fifo_read_data,
   input wire logic                  tdo_o,
   input wire logic                  tdo_oe,
   input wire logic [DATA_WIDTH-1:0] fifo_data_outputs,
   input wire logic                  fifo_data_outputs_oe,
   input wire logic [PTR_WIDTH-1:0]  read_ptr_reg,
   input wire logic [PTR_WIDTH-1:0]  write_ptr_reg
);
   logic       tck_d_reg;
   logic [3:0] fall_reg;
   logic [3:0] trst_reg;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // Ages saturate so long idle stretches never wrap into a window
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tck_d_reg <= 1'b0;
         fall_reg  <= 4'hF;
         trst_reg  <= 4'hF;
      end else begin
         tck_d_reg <= tck;
         fall_reg  <= (tck_d_reg && !tck) ? 4'h0 : fall_reg + {3'h0, fall_reg != 4'hF};
         trst_reg  <= !trst_b ? 4'h0 : trst_reg + {3'h0, trst_reg != 4'hF};
      end
   end
   a_tdo_at_fall: assert property ($changed(tdo_o) && trst_reg > 4'h5 |-> fall_reg < 4'h7)
      else $error("tdo moved away from a fall");
   a_oe_opens_fall: assert property ($rose(tdo_oe) |-> fall_reg < 4'h7)
      else $error("tdo enable rose away from a fall");
   a_oe_shuts_fall: assert property ($fell(tdo_oe) && trst_reg > 4'h5 |-> fall_reg < 4'h7)
      else $error("tdo enable fell away from a fall");
   a_trst_hides: assert property (!trst_b [*4] |=> !tdo_oe && !fifo_data_outputs_oe)
      else $error("outputs driven during test reset");
   a_oe_sticky: assert property ($fell(fifo_data_outputs_oe) |-> trst_reg < 4'h6)
      else $error("data enable lost without test reset");
   a_mrst_clears: assert property (!fifo_master_reset_b [*4] |-> fifo_data_outputs == '0 && read_ptr_reg == '0)
      else $error("master reset did not clear");
   a_data_follows: assert property (fifo_master_reset_b [*5] |=> fifo_data_outputs == $past(fifo_read_data))
      else $error("data output did not follow");
   a_wptr_zero: assert property (write_ptr_reg == '0)
      else $error("write pointer not zero");
endmodule // fbst_tap_assertions
bind fbst_tap fbst_tap_assertions #(.DATA_WIDTH(DATA_WIDTH), .PTR_WIDTH(PTR_WIDTH)) u_chk (
   .mclk(mclk), .rst_b(rst_b), .tck(tck), .trst_b(trst_b), .fifo_master_reset_b(fifo_master_reset_b),
   .fifo_read_data(fifo_read_data), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .fifo_data_outputs(fifo_data_outputs),
   .fifo_data_outputs_oe(fifo_data_outputs_oe), .read_ptr_reg(read_ptr_reg), .write_ptr_reg(write_ptr_reg));

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import fbst_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        mrst_b = 1'b1;
   logic [35:0] rdata = 36'h0;
   logic [31:0] v;
   wire         tck, tms, tdi, trst_b, tdo, tdo_oe, d_oe;
   wire  [35:0] dq;
   wire  [15:0] rp, wp;
   int          errors = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   always #5 mclk = ~mclk;
   fbst_tap u_dut (.mclk(mclk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
      .fifo_master_reset_b(mrst_b), .fifo_read_data(rdata), .tdo_o(tdo), .tdo_oe(tdo_oe),
      .fifo_data_outputs(dq), .fifo_data_outputs_oe(d_oe), .read_ptr_reg(rp), .write_ptr_reg(wp));
   // Released pin shows the inverse, so a late enable shows up as wrong bits
   fbst_ctrl_model u_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo_oe ? tdo : ~tdo));
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic t_no_reset();
      tick(20);
      check(36'(d_oe), 36'h0);
      check(36'(tdo_oe), 36'h0);
      u_ctrl.walk(8'h1F, 5);
      tick(10);
      check(36'(d_oe), 36'h1);
   endtask
   task automatic t_idcode();
      u_ctrl.walk(8'h02, 4);
      #50 check(36'(tdo_oe), 36'h1);
      u_ctrl.scan(32, 32'hFFFF_FFFF, v);
      check(36'(v), 36'(FBST_ID_VALUE));
      #50 check(36'(tdo_oe), 36'h0);
      u_ctrl.walk(8'h01, 2);
   endtask
   task automatic t_bypass();
      u_ctrl.walk(8'h03, 4);
      u_ctrl.scan(4, {28'h0, FBST_INS_BYPASS}, v);
      check(36'(v[3:0]), 36'(FBST_IR_CAPTURE));
      u_ctrl.walk(8'h05, 5);
      u_ctrl.scan(8, 32'h0000_00A5, v);
      check(36'(v[7:0]), 36'h4A);
      u_ctrl.walk(8'h01, 2);
   endtask
   task automatic t_trst();
      u_ctrl.set_trst(1'b0);
      tick(10);
      check(36'(d_oe), 36'h0);
      u_ctrl.set_trst(1'b1);
      tick(10);
      check(36'(d_oe), 36'h1);
      t_idcode();
   endtask
   // System reset in mid-run leaves the TAP unreset until trst, tied to master reset
   task automatic t_mrst();
      rdata = 36'h9_8765_4321;
      tick(3);
      check(dq, 36'h9_8765_4321);
      rst_b = 1'b0;
      tick(2);
      rst_b = 1'b1;
      tick(2);
      check(36'(d_oe), 36'h0);
      mrst_b = 1'b0;
      u_ctrl.set_trst(1'b0);
      tick(6);
      check(dq, 36'h0);
      check(36'(rp), 36'h0);
      check(36'(wp), 36'h0);
      check(36'(d_oe), 36'h0);
      mrst_b = 1'b1;
      u_ctrl.set_trst(1'b1);
      tick(6);
      check(dq, 36'h9_8765_4321);
      check(36'(d_oe), 36'h1);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      tick(2);
      rst_b = 1'b1;
      tick(3);
      t_no_reset();
      t_idcode();
      t_bypass();
      t_trst();
      t_mrst();
      final_report();
   end
endmodule // testbench
